//--- verilog/nv_access_pkg.sv
package nv_access_pkg;

   // ------------------------------------------------------------
   // I/O space offsets
   // ------------------------------------------------------------
   localparam logic [5:0] NV_CONTROL_OFFSET = 6'h1C;
   localparam logic [5:0] NV_DATA_OFFSET = 6'h1D;
   localparam logic [5:0] NV_ADDRESS_OFFSET = 6'h1E;

   // ------------------------------------------------------------
   // Control register field positions
   // ------------------------------------------------------------
   localparam int CTRL_READ_STROBE_BIT = 0;
   localparam int CTRL_WRITE_STROBE_BIT = 1;
   localparam int CTRL_MASTER_WE_BIT = 2;
   localparam int CTRL_READY_IRQ_EN_BIT = 3;

   // ------------------------------------------------------------
   // Sizes, reset values and timing
   // ------------------------------------------------------------
   localparam int NV_ADDR_WIDTH = 6;
   localparam int NV_DEPTH = 64;
   localparam logic [7:0] NV_DATA_RESET = 8'h00;
   localparam logic [2:0] MASTER_WE_HOLD_CYCLES = 3'h4;
   localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
   localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
   localparam int WRITE_OSC_CYCLES_DEFAULT = 8192;

   // ------------------------------------------------------------
   // I/O request carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic [5:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } io_req_t;

   typedef enum logic {
      NV_IDLE,
      NV_WRITING
   } nv_state_t;

endpackage

//--- verilog/eeprom_access_control.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_access_control #(
   parameter int WRITE_OSC_CYCLES = nv_access_pkg::WRITE_OSC_CYCLES_DEFAULT
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // I/O register port
   input wire nv_access_pkg::io_req_t io_req_i,
   output logic [7:0] io_rdata_o,
   // Core side
   input wire logic core_global_irq_enable_i,
   input wire logic osc_tick_i,
   output logic cpu_stall_o,
   output logic nv_ready_irq_o,
   output logic nv_busy_o
);
   import nv_access_pkg::*;

   localparam int OSC_CNT_W = $clog2(WRITE_OSC_CYCLES + 1);
   localparam logic [OSC_CNT_W-1:0] OSC_LAST = OSC_CNT_W'(WRITE_OSC_CYCLES - 1);

   // ------------------------------------------------------------
   // Storage and registers
   // ------------------------------------------------------------
   logic [7:0] nv_mem [0:NV_DEPTH-1];
   logic [NV_ADDR_WIDTH-1:0] nv_address_reg_ff;
   logic [7:0] nv_data_reg_ff;
   logic nv_ready_irq_enable_ff;
   logic nv_master_write_enable_ff;
   logic [2:0] mwe_cnt_ff;
   nv_state_t state_ff;
   logic [OSC_CNT_W-1:0] osc_cnt_ff;
   logic [2:0] stall_cnt_ff;
   logic stall_ff;
   logic irq_ff;
   logic [7:0] rdata_ff;

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   logic ctrl_wr;
   logic addr_wr;
   logic data_wr;
   logic write_start;
   logic read_start;
   logic write_done;
   logic write_abort;
   logic nxt_write_strobe;
   logic nxt_irq_enable;
   logic [2:0] nxt_stall_cnt;
   logic [7:0] ctrl_view;

   assign ctrl_wr = io_req_i.wr && (io_req_i.addr == NV_CONTROL_OFFSET);
   assign addr_wr = io_req_i.wr && (io_req_i.addr == NV_ADDRESS_OFFSET);
   assign data_wr = io_req_i.wr && (io_req_i.addr == NV_DATA_OFFSET);

   assign write_start = ctrl_wr && io_req_i.wdata[CTRL_WRITE_STROBE_BIT]
                        && nv_master_write_enable_ff && (state_ff == NV_IDLE);
   assign read_start = ctrl_wr && io_req_i.wdata[CTRL_READ_STROBE_BIT];
   assign write_abort = (state_ff == NV_WRITING) && (addr_wr || data_wr);
   assign write_done = (state_ff == NV_WRITING) && osc_tick_i
                       && (osc_cnt_ff == OSC_LAST) && !write_abort;

   assign nxt_write_strobe = write_start
                             || ((state_ff == NV_WRITING) && !write_done && !write_abort);
   assign nxt_irq_enable = ctrl_wr ? io_req_i.wdata[CTRL_READY_IRQ_EN_BIT]
                                   : nv_ready_irq_enable_ff;

   // ------------------------------------------------------------
   // Address register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (addr_wr) begin
         nv_address_reg_ff <= io_req_i.wdata[NV_ADDR_WIDTH-1:0];
      end
   end

   // ------------------------------------------------------------
   // Data register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         nv_data_reg_ff <= NV_DATA_RESET;
      end else if (data_wr) begin
         nv_data_reg_ff <= io_req_i.wdata;
      end else if (read_start) begin
         nv_data_reg_ff <= nv_mem[nv_address_reg_ff];
      end
   end

   // ------------------------------------------------------------
   // Array commit
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (write_done) begin
         nv_mem[nv_address_reg_ff] <= nv_data_reg_ff;
      end
   end

   // ------------------------------------------------------------
   // Ready interrupt enable
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         nv_ready_irq_enable_ff <= 1'b0;
      end else begin
         nv_ready_irq_enable_ff <= nxt_irq_enable;
      end
   end

   // ------------------------------------------------------------
   // Master write enable with self-clear
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         nv_master_write_enable_ff <= 1'b0;
         mwe_cnt_ff <= 3'h0;
      end else if (ctrl_wr && io_req_i.wdata[CTRL_MASTER_WE_BIT]) begin
         nv_master_write_enable_ff <= 1'b1;
         mwe_cnt_ff <= MASTER_WE_HOLD_CYCLES;
      end else if (mwe_cnt_ff > 3'h1) begin
         mwe_cnt_ff <= mwe_cnt_ff - 3'h1;
      end else begin
         nv_master_write_enable_ff <= 1'b0;
         mwe_cnt_ff <= 3'h0;
      end
   end

   // ------------------------------------------------------------
   // Self-timed write sequencer
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         state_ff <= NV_IDLE;
         osc_cnt_ff <= '0;
      end else begin
         unique case (state_ff)
            NV_IDLE: begin
               osc_cnt_ff <= '0;
               if (write_start) begin
                  state_ff <= NV_WRITING;
               end
            end
            NV_WRITING: begin
               if (write_abort || write_done) begin
                  state_ff <= NV_IDLE;
                  osc_cnt_ff <= '0;
               end else if (osc_tick_i) begin
                  osc_cnt_ff <= osc_cnt_ff + OSC_CNT_W'(1);
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Processor stall
   // ------------------------------------------------------------
   always_comb begin
      if (read_start) begin
         nxt_stall_cnt = READ_STALL_CYCLES;
      end else if (write_start) begin
         nxt_stall_cnt = WRITE_STALL_CYCLES;
      end else if (stall_cnt_ff != 3'h0) begin
         nxt_stall_cnt = stall_cnt_ff - 3'h1;
      end else begin
         nxt_stall_cnt = 3'h0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         stall_cnt_ff <= 3'h0;
         stall_ff <= 1'b0;
      end else begin
         stall_cnt_ff <= nxt_stall_cnt;
         stall_ff <= (nxt_stall_cnt != 3'h0);
      end
   end

   // ------------------------------------------------------------
   // Ready interrupt level
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq_enable && core_global_irq_enable_i && !nxt_write_strobe;
      end
   end

   // ------------------------------------------------------------
   // Read-back
   // ------------------------------------------------------------
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[CTRL_READY_IRQ_EN_BIT] = nv_ready_irq_enable_ff;
      ctrl_view[CTRL_MASTER_WE_BIT] = nv_master_write_enable_ff;
      ctrl_view[CTRL_WRITE_STROBE_BIT] = (state_ff == NV_WRITING);
      ctrl_view[CTRL_READ_STROBE_BIT] = 1'b0;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         rdata_ff <= 8'h00;
      end else if (io_req_i.rd) begin
         unique case (io_req_i.addr)
            NV_CONTROL_OFFSET: rdata_ff <= ctrl_view;
            NV_DATA_OFFSET: rdata_ff <= nv_data_reg_ff;
            NV_ADDRESS_OFFSET: rdata_ff <= {2'h0, nv_address_reg_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   assign io_rdata_o = rdata_ff;
   assign cpu_stall_o = stall_ff;
   assign nv_ready_irq_o = irq_ff;
   assign nv_busy_o = (state_ff == NV_WRITING);

endmodule

`default_nettype wire

//--- testbench/nv_access_sva.sv
`timescale 1ns/100ps
`default_nettype none
module nv_access_sva #(
   parameter int WRITE_OSC_CYCLES = nv_access_pkg::WRITE_OSC_CYCLES_DEFAULT
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire nv_access_pkg::io_req_t io_req_i,
   input wire logic [7:0] io_rdata_o,
   input wire logic core_global_irq_enable_i,
   input wire logic osc_tick_i,
   input wire logic cpu_stall_o,
   input wire logic nv_ready_irq_o,
   input wire logic nv_busy_o
);
   import nv_access_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   logic [2:0] mwe_left_ff;
   int ticks_ff;
   wire logic [7:0] wd = io_req_i.wdata;
   wire logic wc = io_req_i.wr && io_req_i.addr == NV_CONTROL_OFFSET;
   wire logic rc = io_req_i.rd && io_req_i.addr == NV_CONTROL_OFFSET;
   wire logic mwe_on = mwe_left_ff != 3'h0;
   wire logic start = wc && wd[1] && !nv_busy_o && mwe_on;
   wire logic abort = nv_busy_o && io_req_i.wr
                      && io_req_i.addr inside {NV_DATA_OFFSET, NV_ADDRESS_OFFSET};
   // -----------------------------------------------
   // Master enable window and write tick count
   // -----------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) mwe_left_ff <= 3'h0;
      else if (wc && wd[2]) mwe_left_ff <= 3'h4;
      else if (mwe_on) mwe_left_ff <= mwe_left_ff - 3'h1;
   end
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || !nv_busy_o) ticks_ff <= 0;
      else if (osc_tick_i) ticks_ff <= ticks_ff + 1;
   end
   a_ctrl_upper_zero: assert property (rc |=> io_rdata_o[7:4] == 4'h0)
      else $error("control upper bits not zero");
   a_read_strobe_clear: assert property (rc |=> !io_rdata_o[0])
      else $error("read strobe reads one");
   a_mwe_window: assert property (rc |=> io_rdata_o[2] == $past(mwe_on))
      else $error("master enable window wrong");
   a_start_busy: assert property (start |=> nv_busy_o && !nv_ready_irq_o)
      else $error("write did not start");
   a_no_mwe_ignore: assert property (wc && wd[1] && !nv_busy_o && !mwe_on |=> !nv_busy_o)
      else $error("write started without master enable");
   a_write_stall: assert property (start && !wd[0] |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
      else $error("write stall length wrong");
   a_read_stall: assert property (wc && wd[0] |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
      else $error("read stall length wrong");
   a_write_time: assert property ($fell(nv_busy_o) && !$past(abort) |-> ticks_ff == WRITE_OSC_CYCLES)
      else $error("write time wrong");
   a_abort_clears: assert property (abort |=> !nv_busy_o)
      else $error("abort did not stop write");
   a_irq_gated: assert property (nv_ready_irq_o |-> !nv_busy_o && $past(core_global_irq_enable_i))
      else $error("ready request while busy or disabled");
   a_addr_upper: assert property (io_req_i.rd && io_req_i.addr == 6'h1E |=> io_rdata_o[7:6] == 2'h0)
      else $error("address upper bits not zero");
   c_start: cover property (start);
   c_abort: cover property (abort);
   c_ready: cover property ($rose(nv_ready_irq_o));
endmodule
bind eeprom_access_control nv_access_sva #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) u_sva (
   .core_clk_i(core_clk_i),
   .rstn_i(rstn_i),
   .io_req_i(io_req_i),
   .io_rdata_o(io_rdata_o),
   .core_global_irq_enable_i(core_global_irq_enable_i),
   .osc_tick_i(osc_tick_i),
   .cpu_stall_o(cpu_stall_o),
   .nv_ready_irq_o(nv_ready_irq_o),
   .nv_busy_o(nv_busy_o)
);
`default_nettype wire

//--- testbench/nv_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module nv_core_model (
   // Clock and status
   input wire logic core_clk_i,
   input wire logic stall_i,
   input wire logic busy_i,
   input wire logic [7:0] rdata_i,
   // Requests
   output nv_access_pkg::io_req_t io_req_o,
   output logic osc_tick_o,
   output logic gie_o
);
   import nv_access_pkg::*;
   logic [1:0] div_ff = 2'h0;
   initial io_req_o = '0;
   initial gie_o = 1'b0;
   // Free-running oscillator, one tick every third clock
   always @(posedge core_clk_i) div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
   assign osc_tick_o = div_ff == 2'h2;
   task automatic access(input logic [5:0] a, input logic w, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge core_clk_i) #1;
      while (stall_i) @(posedge core_clk_i) #1;
      io_req_o = '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge core_clk_i) #1;
      q = rdata_i;
      // Released bus shows the inverse, never the old value
      io_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
   task automatic nv_write(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      logic g;
      g = gie_o;
      while (busy_i) @(posedge core_clk_i) #1;
      gie_o = 1'b0;
      access(NV_ADDRESS_OFFSET, 1'b1, {2'h0, a}, q);
      access(NV_DATA_OFFSET, 1'b1, d, q);
      access(NV_CONTROL_OFFSET, 1'b1, 8'h0C, q);
      access(NV_CONTROL_OFFSET, 1'b1, 8'h0A, q);
      gie_o = g;
   endtask
endmodule
`default_nettype wire

//--- testbench/eeprom_access_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module eeprom_access_control_tb_top;
   import nv_access_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   io_req_t req;
   logic [7:0] rdata;
   logic [7:0] q;
   logic tick, gie, stall, irq, busy;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   always #25 clk = ~clk;
   eeprom_access_control #(.WRITE_OSC_CYCLES(8)) dut (.core_clk_i(clk), .rstn_i(rstn),
      .io_req_i(req), .io_rdata_o(rdata), .core_global_irq_enable_i(gie),
      .osc_tick_i(tick), .cpu_stall_o(stall), .nv_ready_irq_o(irq), .nv_busy_o(busy));
   nv_core_model core (.core_clk_i(clk), .stall_i(stall), .busy_i(busy), .rdata_i(rdata),
      .io_req_o(req), .osc_tick_o(tick), .gie_o(gie));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      core.access(a, 1'b0, 8'h00, q);
      check(q, exp);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      core.access(a, 1'b1, d, q);
   endtask
   task automatic print_verdict;
      $display("checks=%0d failures=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      rd(NV_CONTROL_OFFSET, 8'h00);
      rd(NV_DATA_OFFSET, NV_DATA_RESET);
      wr(NV_ADDRESS_OFFSET, 8'hFF);
      rd(NV_ADDRESS_OFFSET, 8'h3F);
      wr(NV_CONTROL_OFFSET, 8'h02);
      check({7'h0, busy}, 8'h00);
      wr(NV_CONTROL_OFFSET, 8'h04);
      rd(NV_CONTROL_OFFSET, 8'h04);
      repeat (4) @(posedge clk);
      rd(NV_CONTROL_OFFSET, 8'h00);
      wr(NV_CONTROL_OFFSET, 8'h02);
      check({7'h0, busy}, 8'h00);
      core.gie_o = 1'b1;
      core.nv_write(6'h2A, 8'h5A);
      check({5'h0, stall, busy, irq}, 8'h06);
      for (int i = 0; i < 100 && busy; i++) @(posedge clk);
      #1 check({6'h0, busy, irq}, 8'h01);
      core.gie_o = 1'b0;
      @(posedge clk) #1 check({7'h0, irq}, 8'h00);
      wr(NV_DATA_OFFSET, 8'h00);
      wr(NV_CONTROL_OFFSET, 8'h01);
      check({7'h0, stall}, 8'h01);
      rd(NV_DATA_OFFSET, 8'h5A);
      rd(NV_CONTROL_OFFSET, 8'h00);
      core.nv_write(6'h10, 8'h77);
      wr(NV_DATA_OFFSET, 8'h11);
      check({7'h0, busy}, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
